// >>> src/dbirq_consts.vh
// Constants for the debounced input block with edge interrupts.
`ifndef DBIRQ_CONSTS_VH
`define DBIRQ_CONSTS_VH

// Register byte offsets on the APB slave.
`define DBIRQ_OFS_FILTER_CFG  8'h00
`define DBIRQ_OFS_EDGE_SEL    8'h04
`define DBIRQ_OFS_IRQ_EN      8'h08
`define DBIRQ_OFS_IRQ_FLAGS   8'h0c
`define DBIRQ_OFS_IRQ_CTRL    8'h10
`define DBIRQ_OFS_IRQ_CLEAR   8'h14
`define DBIRQ_OFS_PORT_BASE   8'h20
`define DBIRQ_OFS_PORT_LAST   8'h3c

// Field positions inside the filter configuration byte.
`define DBIRQ_CFG_EN_LSB      0
`define DBIRQ_CFG_EN_MSB      3
`define DBIRQ_CFG_FACTOR_LSB  4
`define DBIRQ_CFG_FACTOR_MSB  7

// Reset values.
`define DBIRQ_RST_FILTER_CFG  8'h10
`define DBIRQ_RST_EDGE_SEL    8'h00
`define DBIRQ_RST_IRQ_EN      8'h00
`define DBIRQ_RST_IRQ_CTRL    1'b0

// Debounce tick: time in milliseconds, clock rate in MHz, and cycles.
`define DBIRQ_TICK_MS         10
`define DBIRQ_CLK_MHZ         250
`define DBIRQ_TICK_CYCLES     (`DBIRQ_TICK_MS * `DBIRQ_CLK_MHZ * 1000)

// Geometry.
`define DBIRQ_NUM_PORTS       8
`define DBIRQ_FILT_PORTS      4
`define DBIRQ_PORT_W          8

`endif

// >>> src/dbirq_filter.v
// Per-port debounce filter, one counter per channel, advanced per tick.
`include "dbirq_consts.vh"

module dbirq_filter #(
    parameter W = `DBIRQ_PORT_W
) (
    // Clock and reset.
    input  wire         clk_i,
    input  wire         rst_i,
    // Control.
    input  wire         enable_i,
    input  wire         tick_i,
    input  wire [3:0]   factor_i,
    // Data.
    input  wire [W-1:0] din_i,
    output reg  [W-1:0] dout_o
);

    reg [3:0] cnt [0:W-1];
    wire [4:0] factor_eff;
    integer i;

    // A zero factor is illegal; it behaves as the shortest period.
    assign factor_eff = (factor_i == 4'h0) ? 5'h01 : {1'b0, factor_i};

    // Each channel counts ticks on which its input differs from the output.
    // Any tick on which they agree restarts the count, so short pulses
    // of either level are dropped as noise.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dout_o <= {W{1'b0}};
            for (i = 0; i < W; i = i + 1)
                cnt[i] <= 4'h0;
        end
        else
        begin
            for (i = 0; i < W; i = i + 1)
            begin
                if (!enable_i)
                begin
                    dout_o[i] <= din_i[i];
                    cnt[i]    <= 4'h0;
                end
                else if (tick_i)
                begin
                    if (din_i[i] == dout_o[i])
                        cnt[i] <= 4'h0;
                    else if (({1'b0, cnt[i]} + 5'h01) >= factor_eff)
                    begin
                        dout_o[i] <= din_i[i];
                        cnt[i]    <= 4'h0;
                    end
                    else
                        cnt[i] <= cnt[i] + 4'h1;
                end
            end
        end
    end

endmodule

// >>> src/dbirq_top.v
// Debounced isolated input block with APB registers and edge interrupts.
//
// What this block does
// - The inputs form eight ports; ports 0 to 3 are filtered, each filter switched on alone.
// - Bits 0 to 3 of the filter byte enable the filter of ports 0 to 3.
// - Bits 4 to 7 of the filter byte hold one factor, 1 to 15, for all.
// - A filter's debounce period is the factor times a 10 ms tick.
// - Input data reads return the 8 bits of one port chosen from 0 to 7.
// - An edge select bit of 0 picks the rising edge, 1 the falling edge.
// - A channel enable bit of 1 lets its edge interrupt, 0 suppresses it.
// - Flag bit n reads 1 when port 0 channel n caused an interrupt.
// - After service software clears the flags and all of them drop.
// - A global disable stops every channel interrupt whatever the mask.
// - A filter passes a level only after it held on factor successive ticks.
// - The edge change detector fires on low-high or high-low as chosen.
//
// Only port 0 raises edge interrupts; the other ports are read only.
// Ports 4 to 7 have no filter and show the synchronised level two clocks
// after the pin. A filter adds up to factor ticks of latency, so
// with the largest factor a change waits fifteen ticks to appear.
// The factor is shared: changing it mid-count applies on the next tick.
// Writing a zero factor is tolerated and acts as a factor of one.
`include "dbirq_consts.vh"

module dbirq_top #(
    parameter NUM_PORTS   = `DBIRQ_NUM_PORTS,
    parameter PORT_W      = `DBIRQ_PORT_W,
    parameter TICK_CYCLES = `DBIRQ_TICK_CYCLES,
    parameter TICK_W      = 22
) (
    // Clock and reset.
    input  wire                        clk_i,
    input  wire                        rst_i,
    // Field inputs, asynchronous to the clock.
    input  wire [NUM_PORTS*PORT_W-1:0] input_channel_i,
    // APB slave.
    input  wire                        psel_i,
    input  wire                        penable_i,
    input  wire                        pwrite_i,
    input  wire [7:0]                  paddr_i,
    input  wire [31:0]                 pwdata_i,
    output reg  [31:0]                 prdata_o,
    output reg                         pready_o,
    output reg                         pslverr_o,
    // Interrupt request, level.
    output reg                         irq_o
);

    localparam NCH = NUM_PORTS * PORT_W;

    // Tick period as a counter limit, cut to the counter width on purpose;
    // TICK_W must be wide enough to hold TICK_CYCLES - 1.
    localparam integer      TICK_LAST_INT = TICK_CYCLES - 1;
    localparam [TICK_W-1:0] TICK_LAST     = TICK_LAST_INT[TICK_W-1:0];

    // Software-visible registers.
    reg [7:0]          filter_config_byte;
    reg [PORT_W-1:0]   edge_select_bits;
    reg [PORT_W-1:0]   channel_irq_enable_bits;
    reg [PORT_W-1:0]   channel_irq_flags;
    reg                irq_global_en;

    // Fields of the filter configuration byte.
    wire [3:0]         filt_enable;
    wire [3:0]         filt_factor;

    // Input path.
    reg [NCH-1:0]      sync_meta;
    reg [NCH-1:0]      sync_in;
    wire [NCH-1:0]     filt_in;
    reg [TICK_W-1:0]   presc_cnt;
    reg                tick;

    // Edge change detector state.
    reg [PORT_W-1:0]   port0_prev;
    reg [PORT_W-1:0]   edge_hit;
    reg [PORT_W-1:0]   next_flags;

    // Bus decode.
    wire               apb_access;
    wire               apb_wr;
    wire               apb_rd_cycle;
    reg [31:0]         rd_value;
    reg                rd_err;
    wire               addr_is_port;
    wire [2:0]         port_selector;
    wire               wr_flags;
    wire               wr_clear;
    wire               next_irq;

    // Picks one port's byte out of the full filtered vector.
    function [PORT_W-1:0] port_byte;
        input [NCH-1:0] data;
        input [2:0]     sel;
        integer         k;
        begin
            port_byte = {PORT_W{1'b0}};
            for (k = 0; k < PORT_W; k = k + 1)
                port_byte[k] = data[sel * PORT_W + k];
        end
    endfunction

    // True when a committed write targets the given register offset.
    function wr_hit;
        input       wr;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = wr && (addr == ofs);
        end
    endfunction

    // Two flip-flops on every field input; only the second is read.
    // The first may go metastable, so no logic but the second looks at it.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_meta <= {NCH{1'b0}};
            sync_in   <= {NCH{1'b0}};
        end
        else
        begin
            sync_meta <= input_channel_i;
            sync_in   <= sync_meta;
        end
    end

    // Prescaler for the debounce tick; one-cycle enable pulse per period.
    // The counter free-runs so all ports share one phase of the tick.
    // A port switched on mid-period may see its first tick early.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            presc_cnt <= {TICK_W{1'b0}};
            tick      <= 1'b0;
        end
        else if (presc_cnt == TICK_LAST)
        begin
            presc_cnt <= {TICK_W{1'b0}};
            tick      <= 1'b1;
        end
        else
        begin
            presc_cnt <= presc_cnt + {{(TICK_W-1){1'b0}}, 1'b1};
            tick      <= 1'b0;
        end
    end

    // Field split of the filter byte; the factor is common to all ports.
    assign filt_enable = filter_config_byte[`DBIRQ_CFG_EN_MSB:
                                            `DBIRQ_CFG_EN_LSB];
    assign filt_factor = filter_config_byte[`DBIRQ_CFG_FACTOR_MSB:
                                            `DBIRQ_CFG_FACTOR_LSB];

    // Four filtered ports, each enabled by its own bit, one shared factor.
    genvar p;
    generate
        for (p = 0; p < `DBIRQ_FILT_PORTS; p = p + 1)
        begin : g_filt
            dbirq_filter #(
                .W        (PORT_W)
            ) u_filt (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .enable_i (filt_enable[p]),
                .tick_i   (tick),
                .factor_i (filt_factor),
                .din_i    (sync_in[p*PORT_W +: PORT_W]),
                .dout_o   (filt_in[p*PORT_W +: PORT_W])
            );
        end
    endgenerate

    // Ports above the filtered ones carry the synchronised level as is.
    assign filt_in[NCH-1:`DBIRQ_FILT_PORTS*PORT_W] =
        sync_in[NCH-1:`DBIRQ_FILT_PORTS*PORT_W];

    // Remember the previous port 0 level for edge detection.
    // Its reset value is the idle low level, so no false edge follows reset.
    always @(posedge clk_i)
    begin
        if (rst_i)
            port0_prev <= {PORT_W{1'b0}};
        else
            port0_prev <= filt_in[PORT_W-1:0];
    end

    // Edge change detector: rising where the select bit is 0, falling
    // where it is 1, then gated by the channel enable and global enable.
    // A channel masked off never sets its flag, not only its request.
    integer c;
    always @*
    begin
        edge_hit = {PORT_W{1'b0}};
        for (c = 0; c < PORT_W; c = c + 1)
        begin
            if (edge_select_bits[c])
                edge_hit[c] = port0_prev[c] & ~filt_in[c];
            else
                edge_hit[c] = ~port0_prev[c] & filt_in[c];
        end
        edge_hit = edge_hit & channel_irq_enable_bits;
        if (!irq_global_en)
            edge_hit = {PORT_W{1'b0}};
    end

    // APB phases: writes commit and read data is valid on the
    // second access cycle, when pready is high.
    // A write thus lands at the same edge at which the master sees pready.
    assign apb_access   = psel_i & penable_i;
    assign apb_rd_cycle = apb_access & ~pready_o;
    assign apb_wr       = apb_access & pready_o & pwrite_i;

    // Port data window: one word per port, selector from the address.
    assign addr_is_port = (paddr_i >= `DBIRQ_OFS_PORT_BASE) &&
                          (paddr_i <= `DBIRQ_OFS_PORT_LAST) &&
                          (paddr_i[1:0] == 2'b00);
    assign port_selector = paddr_i[4:2];

    // Write strobes of the two registers that clear flags.
    assign wr_flags = wr_hit(apb_wr, paddr_i, `DBIRQ_OFS_IRQ_FLAGS);
    assign wr_clear = wr_hit(apb_wr, paddr_i, `DBIRQ_OFS_IRQ_CLEAR);

    // Flag update: a new edge sets its flag even in the cycle that a
    // clear lands, so no event is lost to a racing clear.
    always @*
    begin
        next_flags = channel_irq_flags;
        if (wr_flags)
            next_flags = next_flags & ~pwdata_i[PORT_W-1:0];
        if (wr_clear)
            next_flags = {PORT_W{1'b0}};
        next_flags = next_flags | edge_hit;
    end

    // Request level from the next flags, so it rises with the flag itself.
    assign next_irq = irq_global_en &
                      (|(next_flags & channel_irq_enable_bits));

    // Read decode; unmapped offsets answer zero with an error.
    // Reads have no side effect; flags clear only on a write.
    always @*
    begin
        rd_value = 32'h0000_0000;
        rd_err   = 1'b0;
        if (addr_is_port)
            rd_value[PORT_W-1:0] = port_byte(filt_in, port_selector);
        else
        begin
            case (paddr_i)
                `DBIRQ_OFS_FILTER_CFG:
                    rd_value[7:0] = filter_config_byte;
                `DBIRQ_OFS_EDGE_SEL:
                    rd_value[PORT_W-1:0] = edge_select_bits;
                `DBIRQ_OFS_IRQ_EN:
                    rd_value[PORT_W-1:0] = channel_irq_enable_bits;
                `DBIRQ_OFS_IRQ_FLAGS:
                    rd_value[PORT_W-1:0] = channel_irq_flags;
                `DBIRQ_OFS_IRQ_CTRL:
                    rd_value[0] = irq_global_en;
                `DBIRQ_OFS_IRQ_CLEAR:
                    rd_value = 32'h0000_0000;
                default:
                    rd_err = 1'b1;
            endcase
        end
    end

    // Bus answer: one wait state, then pready with registered data.
    // The wait state buys a flop-driven prdata at a small latency cost.
    // The error flag comes with pready for reads and writes alike.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else if (apb_rd_cycle)
        begin
            pready_o  <= 1'b1;
            pslverr_o <= rd_err;
            if (!pwrite_i)
                prdata_o <= rd_value;
            else
                prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
    end

    // Control registers written by software.
    // Writes to the flag, clear and port offsets leave these untouched.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            filter_config_byte      <= `DBIRQ_RST_FILTER_CFG;
            edge_select_bits        <= `DBIRQ_RST_EDGE_SEL;
            channel_irq_enable_bits <= `DBIRQ_RST_IRQ_EN;
            irq_global_en           <= `DBIRQ_RST_IRQ_CTRL;
        end
        else if (apb_wr)
        begin
            case (paddr_i)
                `DBIRQ_OFS_FILTER_CFG:
                    filter_config_byte <= pwdata_i[7:0];
                `DBIRQ_OFS_EDGE_SEL:
                    edge_select_bits <= pwdata_i[PORT_W-1:0];
                `DBIRQ_OFS_IRQ_EN:
                    channel_irq_enable_bits <= pwdata_i[PORT_W-1:0];
                `DBIRQ_OFS_IRQ_CTRL:
                    irq_global_en <= pwdata_i[0];
                default:
                    irq_global_en <= irq_global_en;
            endcase
        end
    end

    // Sticky flags and the level interrupt output.
    // Disabling globally also drops the request line one clock after the write lands.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            channel_irq_flags <= {PORT_W{1'b0}};
            irq_o             <= 1'b0;
        end
        else
        begin
            channel_irq_flags <= next_flags;
            irq_o             <= next_irq;
        end
    end

endmodule

// >>> testbench/dbirq_field.sv
// Field-side model that drives the isolated input lines.
module dbirq_field (
    // Clock.
    input  wire logic        clk_i,
    // Commanded levels and a noise pulse request.
    input  wire logic [63:0] level_i,
    input  wire logic [63:0] flip_i,
    input  wire logic [7:0]  len_i,
    input  wire logic        go_i,
    // Lines towards the block.
    output wire logic [63:0] input_channel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left = 8'h00;

    // Count down a noise pulse; it must stay shorter than a debounce period.
    always @(posedge clk_i)
    begin
        if (go_i)
            left <= len_i;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end

    // Inverted lines while a pulse runs, the plain level otherwise.
    assign input_channel_o = (left != 8'h00) ? level_i ^ flip_i : level_i;
endmodule

// >>> testbench/dbirq_asserts.sv
// Port checker for the debounced input block.
module dbirq_asserts (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Field inputs.
    input wire logic [63:0] input_channel_i,
    // APB.
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Interrupt.
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mapped offsets; anything else must answer with an error.
    wire mapped = paddr_i[1:0] == 2'h0 &&
        (paddr_i <= 8'h14 || (paddr_i >= 8'h20 && paddr_i <= 8'h3c));
    wire [63:0] shifted = input_channel_i >> {paddr_i[4:2], 3'h0};
    wire commit = psel_i && penable_i && pready_o && pwrite_i;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside access phase");
    a_err_decode: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("pslverr wrong for offset");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_port_data: assert property (pready_o && !pwrite_i &&
        paddr_i[7:4] == 4'h3 && input_channel_i == $past(input_channel_i, 4)
        |-> prdata_o[7:0] == shifted[7:0])
        else $error("unfiltered port read wrong");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(commit) ||
        $past(commit, 2))
        else $error("irq dropped without a write");

    cover property (pready_o && pslverr_o);
    cover property ($rose(irq_o));
    cover property (pready_o && !pwrite_i && paddr_i[5]);
endmodule

// >>> testbench/dbirq_top_test.sv
// Self-checking bench for the debounced input block.
module dbirq_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    localparam logic [63:0] PAT = 64'hf0e1d2c3b4a59687;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [63:0] level = 64'h0;
    logic [63:0] flip = 64'h0;
    logic [7:0]  glen = 8'h00;
    logic        go = 1'b0;
    wire  [63:0] input_channel_i;
    wire  [31:0] prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         irq_o;
    logic [31:0] rd;
    logic        er;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;

    dbirq_field dbirq_field_i (.clk_i(clk_i), .level_i(level), .flip_i(flip),
        .len_i(glen), .go_i(go), .input_channel_o(input_channel_i));
    dbirq_top #(.TICK_CYCLES(8)) dbirq_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .input_channel_i(input_channel_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o));

    // Clock of 4 ns.
    always #2 clk_i = ~clk_i;

    // A hang ends the run as a failure.
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk_d(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task chk_b(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %b got %b", nm, exp, got);
        end
    endtask

    // One APB transfer; the answer is taken at the edge pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_d(nm, exp, rd);
    endtask

    task irq_chk(input logic exp);
        @(negedge clk_i);
        chk_b("irq", exp, irq_o);
        @(posedge clk_i);
    endtask

    task field(input logic [63:0] v, input int n);
        level <= v;
        repeat (n) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("cfg", 8'h00, 32'h10);
        rdc("edge", 8'h04, 32'h0);
        rdc("mask", 8'h08, 32'h0);
        rdc("flags", 8'h0c, 32'h0);
        rdc("ctrl", 8'h10, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk_b("port 8 err", 1'b1, er);
        apb(1'b1, 8'h18, 32'h1);
        chk_b("wr err", 1'b1, er);
        apb(1'b1, 8'h20, 32'hff);
        chk_b("port wr", 1'b0, er);
        rdc("clear", 8'h14, 32'h0);
        field(PAT, 6);
        for (int p = 0; p < 8; p++)
            rdc("port", 8'h20 + 8'(4 * p), {24'h0, PAT[8 * p +: 8]});
        // Port 0 filtered with factor 3, the other ports follow at once.
        apb(1'b1, 8'h00, 32'h31);
        rdc("cfg", 8'h00, 32'h31);
        field(64'h0, 48);
        flip <= 64'hff;
        glen <= 8'd8;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        field(64'h0, 30);
        rdc("glitch", 8'h20, 32'h0);
        field(64'hffff, 2);
        rdc("early", 8'h20, 32'h0);
        rdc("port 1", 8'h24, 32'hff);
        field(64'hffff, 40);
        rdc("settled", 8'h20, 32'hff);
        // Edge interrupts with filters bypassed.
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b1, 8'h08, 32'h0f);
        apb(1'b1, 8'h04, 32'h0a);
        apb(1'b1, 8'h10, 32'h1);
        field(64'h0, 8);
        apb(1'b1, 8'h14, 32'h0);
        rdc("flags", 8'h0c, 32'h0);
        field(64'hff, 8);
        rdc("flags", 8'h0c, 32'h05);
        irq_chk(1'b1);
        field(64'h0, 8);
        rdc("flags", 8'h0c, 32'h0f);
        apb(1'b1, 8'h0c, 32'h1);
        rdc("flags", 8'h0c, 32'h0e);
        apb(1'b1, 8'h14, 32'h0);
        rdc("flags", 8'h0c, 32'h0);
        irq_chk(1'b0);
        apb(1'b1, 8'h08, 32'h0);
        field(64'hff, 8);
        rdc("flags", 8'h0c, 32'h0);
        apb(1'b1, 8'h08, 32'hff);
        apb(1'b1, 8'h10, 32'h0);
        field(64'h0, 8);
        rdc("flags", 8'h0c, 32'h0);
        irq_chk(1'b0);
        apb(1'b1, 8'h10, 32'h1);
        field(64'hff, 8);
        rdc("flags", 8'h0c, 32'hf5);
        irq_chk(1'b1);
        apb(1'b1, 8'h08, 32'h0);
        irq_chk(1'b0);
        give_verdict();
    end
endmodule

bind dbirq_top dbirq_asserts dbirq_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .input_channel_i(input_channel_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o));
